// ===== sim/bcrx_fifo_chk.sv
// Purpose: Port checker for the receive queue host read path.
// Assumes: clk_en is held high by the bench.
// Notes  : Addresses are folded so both mirrored ranges count alike.
`timescale 1ns/100ps
`default_nettype none
module bcrx_fifo_chk (
    input wire logic       sys_clk,
    input wire logic       rst_b,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       rx_byte_valid,
    input wire logic       rx_byte_last,
    input wire logic       rx_byte_ready,
    input wire logic       rx_pool_full_irq,
    input wire logic       rx_message_end_irq,
    input wire logic       rx_queue_readable_flag,
    input wire logic       rx_dma_mode
);
    import bcrx_pkg::*;
    wire logic [7:0] fold = reg_addr & BCRX_MIRROR_MASK;
    wire logic       evt  = rx_pool_full_irq || rx_message_end_irq;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    sequence s_last;
        rx_byte_valid && rx_byte_ready && rx_byte_last;
    endsequence
    sequence s_release;
        reg_wr && fold == BCRX_ADDR_STCMD && reg_wdata[7] && rx_queue_readable_flag;
    endsequence
    //////////////////////////////////////////////////
    AST_END_CAUSE: assert property (s_last |=> rx_message_end_irq && !rx_pool_full_irq)
        else $error("no frame end pulse after last byte");
    AST_FULL_CAUSE: assert property (rx_pool_full_irq |->
        $past(rx_byte_valid) && $past(rx_byte_ready) && !$past(rx_byte_last))
        else $error("pool full pulse without a taken byte");
    AST_EVT_FLAG: assert property (evt |-> rx_queue_readable_flag && !rx_byte_ready)
        else $error("event without readable flag");
    AST_FLAG_RISE: assert property ($rose(rx_queue_readable_flag) && !$past(rx_dma_mode)
        |-> evt)
        else $error("readable flag rose without event");
    AST_RELEASE: assert property (s_release |=> !rx_queue_readable_flag && rx_byte_ready)
        else $error("message complete did not free queue");
    AST_IDLE_WIN: assert property (reg_rd && fold <= BCRX_QUEUE_LAST && !rx_queue_readable_flag
        |=> reg_rdata == BCRX_BYTE_ZERO)
        else $error("window gave data with no block");
    AST_MODE_WR: assert property (reg_wr && fold == BCRX_ADDR_CNTHI
        |=> rx_dma_mode == $past(reg_wdata[7]))
        else $error("mode bit not taken");
    AST_DMA_NO_FULL: assert property ($past(rx_dma_mode) |-> !rx_pool_full_irq)
        else $error("pool full pulse in dma mode");
endmodule
`default_nettype wire

// ===== sim/bcrx_fifo_test.sv
// Purpose: Self-checking bench of the receive queue host read path.
// Assumes: Host reads each block in full and then releases it.
// Notes  : Window reads use random addresses in both mirrored ranges.
`timescale 1ns/100ps
`default_nettype none
module bcrx_fifo_test;
    import bcrx_pkg::*;
    logic        sys_clk, rst_b, reg_wr, reg_rd, go, stall;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, first_byte, got, rx_byte_data;
    logic [11:0] frame_len;
    logic        rx_byte_valid, rx_byte_last, rx_byte_ready, rx_dma_mode;
    logic        rx_pool_full_irq, rx_message_end_irq, rx_queue_readable_flag;
    logic        dma_on;
    int          err_count, checks, seed, sseed, pos;
    int          cycles = 0, pf_seen = 0, me_seen = 0;
    bcrx_fifo DUT (.sys_clk, .rst_b, .clk_en(1'b1), .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .rx_byte_valid, .rx_byte_data, .rx_byte_last, .rx_byte_ready,
        .rx_pool_full_irq, .rx_message_end_irq, .rx_queue_readable_flag, .rx_dma_mode);
    bcrx_rx_src src (.sys_clk, .rst_b, .go, .frame_len, .first_byte, .stall, .rx_byte_ready,
        .rx_byte_valid, .rx_byte_data, .rx_byte_last);
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        stall  <= ($random(sseed) & 3) == 0;
        cycles <= cycles + 1;
        if (rx_pool_full_irq === 1'b1) pf_seen <= pf_seen + 1;
        if (rx_message_end_irq === 1'b1) me_seen <= me_seen + 1;
        if (cycles == 20000) begin
            err_count++;
            report_and_stop();
        end
    end
    //////////////////////////////////////////////////
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e, input string w);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk(w, e, reg_rdata);
    endtask
    task automatic take_block(input int n, input logic [7:0] ev, input int total);
        int i;
        for (i = 0; i < 400 && rx_queue_readable_flag !== 1'b1; i++) @(posedge sys_clk);
        chk("flag", 8'h01, {7'h00, rx_queue_readable_flag});
        rc(BCRX_ADDR_EVENT, ev, "event");
        if (ev[7]) begin
            rc(BCRX_ADDR_CNTLO, 8'(total), "count low");
            rc(BCRX_ADDR_CNTHI, {dma_on, 3'h0, 4'(total >> 8)}, "count high");
        end
        for (i = 0; i < n; i++) rc(8'($random(seed)) & 8'h5F, first_byte + 8'(pos + i), "byte");
        rc(8'h45, 8'h00, "past block");
        wr(BCRX_ADDR_STCMD | 8'h40, 8'h80);
        pos += n;
        #1 chk("flag free", 8'h00, {7'h00, rx_queue_readable_flag});
    endtask
    task automatic frame(input int len);
        int rest;
        int pf0;
        int me0;
        @(posedge sys_clk);
        first_byte <= 8'($random(seed));
        frame_len  <= 12'(len);
        go         <= 1'b1;
        @(posedge sys_clk);
        go <= 1'b0;
        pos = 0;
        pf0 = pf_seen;
        me0 = me_seen;
        for (rest = len; rest > 64; rest -= 64) take_block(64, 8'h40, len);
        take_block(rest, 8'h80, len);
        chk("pool full pulses", 8'(dma_on ? 0 : (len - 1) / 64), 8'(pf_seen - pf0));
        chk("message end pulses", 8'h01, 8'(me_seen - me0));
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    //////////////////////////////////////////////////
    initial begin
        seed = 32'h596b;
        sseed = 32'h596b;
        {err_count, checks} = '0;
        {rst_b, reg_wr, reg_rd, go, dma_on, reg_addr, reg_wdata, first_byte, frame_len} = '0;
        repeat (3) @(posedge sys_clk);
        rst_b <= 1'b1;
        #1 chk("ready", 8'h01, {7'h00, rx_byte_ready});
        rc(8'h5F, 8'h00, "empty window");
        rc(8'h30, 8'h00, "unmapped");
        wr(8'h6D, 8'h80);
        #1 chk("dma pin", 8'h01, {7'h00, rx_dma_mode});
        rc(BCRX_ADDR_CNTHI, 8'h80, "mode");
        dma_on = 1'b1;
        frame(100);
        wr(BCRX_ADDR_CNTHI, 8'h00);
        dma_on = 1'b0;
        #1 chk("dma pin", 8'h00, {7'h00, rx_dma_mode});
        rc(8'h6D, 8'h00, "mode");
        frame(150);
        frame(64);
        frame(300);
        frame(1);
        for (int k = 0; k < 6; k++) frame(1 + ($unsigned($random(seed)) % 200));
        report_and_stop();
    end
endmodule
bind bcrx_fifo bcrx_fifo_chk u_chk (.sys_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .rx_byte_valid, .rx_byte_last, .rx_byte_ready, .rx_pool_full_irq,
    .rx_message_end_irq, .rx_queue_readable_flag, .rx_dma_mode);
`default_nettype wire

// ===== sim/bcrx_rx_src.sv
// Purpose: Receiver model that feeds frames into the queue.
// Assumes: Bytes count up from first_byte; stall slows the source.
// Notes  : Idle data is inverted so a stale byte never looks fresh.
`timescale 1ns/100ps
`default_nettype none
module bcrx_rx_src (
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire logic        go,
    input  wire logic [11:0] frame_len,
    input  wire logic [7:0]  first_byte,
    input  wire logic        stall,
    input  wire logic        rx_byte_ready,
    output logic             rx_byte_valid,
    output logic [7:0]       rx_byte_data,
    output logic             rx_byte_last
);
    logic [11:0] sent_reg;
    logic [11:0] len_reg;
    logic [7:0]  cur;
    logic        pend_reg;
    // An offered byte stays offered until it is taken, whatever stall does.
    always_ff @(posedge sys_clk) begin
        pend_reg <= rst_b && rx_byte_valid && !rx_byte_ready;
    end
    always_ff @(posedge sys_clk) begin
        if (!rst_b || go) begin
            sent_reg <= 12'h000;
            len_reg  <= rst_b ? frame_len : 12'h000;
        end else if (rx_byte_valid && rx_byte_ready) begin
            sent_reg <= sent_reg + 12'h001;
        end
    end
    assign cur           = first_byte + sent_reg[7:0];
    assign rx_byte_valid = (sent_reg < len_reg) && (!stall || pend_reg);
    assign rx_byte_data  = rx_byte_valid ? cur : ~cur;
    assign rx_byte_last  = rx_byte_valid && (sent_reg == len_reg - 12'h001);
endmodule
`default_nettype wire

// ===== src/bcrx_fifo.sv
// Purpose : Host read path of the B-channel receive queue, interrupt mode.
// Assumes : Receiver delivers bytes with a last-of-frame mark; host uses the
//           register port and issues the message-complete command per block.
// Notes   : One 64-byte block is owned by either the receiver or the host.
//
// What this block does
// - Mode bit clear means interrupt-driven transfer, no DMA requests.
// - After either event up to 64 bytes are readable by the host.
// - Queue holds 64 bytes behind a 32-byte window, pointer self-advances.
// - Every window address in both mirrored ranges returns the next byte.
// - Message-end event when a frame or its final part is stored.
// - Pool-full event when 64 bytes of an unfinished frame are stored.
// - Message-complete command frees the queue for further reception.
// - Readable flag set with either event, cleared by message-complete.
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none

module bcrx_fifo (
    input  wire logic                               sys_clk,
    input  wire logic                               rst_b,
    input  wire logic                               clk_en,
    input  wire logic [bcrx_pkg::BCRX_ADDR_W-1:0]   reg_addr,
    input  wire logic [bcrx_pkg::BCRX_DATA_W-1:0]   reg_wdata,
    input  wire logic                               reg_wr,
    input  wire logic                               reg_rd,
    output logic      [bcrx_pkg::BCRX_DATA_W-1:0]   reg_rdata,
    input  wire logic                               rx_byte_valid,
    input  wire logic [bcrx_pkg::BCRX_DATA_W-1:0]   rx_byte_data,
    input  wire logic                               rx_byte_last,
    output logic                                    rx_byte_ready,
    output logic                                    rx_pool_full_irq,
    output logic                                    rx_message_end_irq,
    output logic                                    rx_queue_readable_flag,
    output logic                                    rx_dma_mode
);
    import bcrx_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Address decode.

    // The mirror bit is stripped before every comparison.
    function automatic logic [BCRX_ADDR_W-1:0] fold_addr(
        input logic [BCRX_ADDR_W-1:0] addr
    );
        fold_addr = addr & BCRX_MIRROR_MASK;
    endfunction

    function automatic logic reg_hit(
        input logic [BCRX_ADDR_W-1:0] addr,
        input logic [BCRX_ADDR_W-1:0] target
    );
        reg_hit = (fold_addr(addr) == target);
    endfunction

    bcrx_state_t             state_reg;
    bcrx_state_t             state_next;
    logic [BCRX_CNT_W-1:0]   wr_cnt_reg;
    logic [BCRX_CNT_W-1:0]   wr_cnt_next;
    logic [BCRX_IDX_W-1:0]   rd_idx_reg;
    logic [BCRX_IDX_W-1:0]   rd_idx_next;
    logic [BCRX_CNT_W-1:0]   rd_cnt_reg;
    logic [BCRX_CNT_W-1:0]   rd_cnt_next;
    logic [BCRX_FRM_W-1:0]   frm_cnt_reg;
    logic [BCRX_FRM_W-1:0]   frm_cnt_next;
    logic                    ov_reg;
    logic                    ov_next;
    logic                    end_blk_reg;
    logic                    end_blk_next;
    logic                    pf_blk_reg;
    logic                    pf_blk_next;
    logic                    dma_reg;
    logic                    dma_next;
    logic                    ready_reg;
    logic                    ready_next;
    logic                    pf_irq_reg;
    logic                    pf_irq_next;
    logic                    me_irq_reg;
    logic                    me_irq_next;
    logic [BCRX_DATA_W-1:0]  rdata_reg;
    logic [BCRX_DATA_W-1:0]  rdata_next;
    logic [BCRX_DATA_W-1:0]  store_q;

    wire logic win_rd      = reg_rd && (fold_addr(reg_addr) <= BCRX_QUEUE_LAST);
    wire logic cmd_wr      = reg_wr && reg_hit(reg_addr, BCRX_ADDR_STCMD);
    wire logic mode_wr     = reg_wr && reg_hit(reg_addr, BCRX_ADDR_CNTHI);
    wire logic cmd_release = cmd_wr && reg_wdata[BCRX_BIT_RELEASE];
    wire logic cmd_flush   = cmd_wr && reg_wdata[BCRX_BIT_FLUSH];
    wire logic host_owns   = (state_reg == BCRX_ST_HOST);

    ////////////////////////////////////////////////////////////////////////////
    // Receiver side.

    wire logic accept    = rx_byte_valid && ready_reg;
    wire logic blk_full  = accept && !rx_byte_last && (wr_cnt_reg == BCRX_BLOCK_LAST);
    wire logic blk_end   = accept && rx_byte_last;
    wire logic blk_done  = blk_full || blk_end;

    bcrx_store u_store (
        .sys_clk (sys_clk),
        .clk_en  (clk_en),
        .wr_en   (accept),
        .wr_idx  (wr_cnt_reg[BCRX_IDX_W-1:0]),
        .wr_data (rx_byte_data),
        .rd_idx  (rd_idx_reg),
        .rd_data (store_q)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Ownership of the block.

    // A flush wins over a block that completes in the same cycle: the bytes it
    // would announce are discarded together with the rest.
    // release on command
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            BCRX_ST_FILL: begin
                if (blk_done && !cmd_flush) begin
                    state_next = BCRX_ST_HOST;
                end
            end
            BCRX_ST_HOST: begin
                if (cmd_release || cmd_flush) begin
                    state_next = BCRX_ST_FILL;
                end
            end
            default: begin
                state_next = BCRX_ST_FILL;
            end
        endcase
    end

    // The receiver is held off while the host owns the block; that is the only
    // back-pressure, so a long frame waits for each message-complete.
    assign ready_next = (state_next == BCRX_ST_FILL);

    assign wr_cnt_next = (cmd_flush || (host_owns && cmd_release)) ? BCRX_CNT_ZERO :
                         blk_done                                  ? wr_cnt_reg + BCRX_CNT_ONE :
                         accept                                    ? wr_cnt_reg + BCRX_CNT_ONE :
                                                                     wr_cnt_reg;

    // Frame byte count runs across blocks and restarts once the end block is freed.
    wire logic frame_restart = cmd_flush || (host_owns && cmd_release && end_blk_reg);
    wire logic frm_at_max    = (frm_cnt_reg == BCRX_FRM_MAX);

    assign frm_cnt_next = frame_restart           ? BCRX_FRM_ZERO :
                          (accept && !frm_at_max) ? frm_cnt_reg + BCRX_FRM_ONE :
                                                    frm_cnt_reg;
    assign ov_next      = frame_restart ? 1'b0 : (ov_reg || (accept && frm_at_max));

    assign end_blk_next = (host_owns && (cmd_release || cmd_flush)) ? 1'b0 :
                          (!host_owns && blk_end && !cmd_flush)      ? 1'b1 :
                                                                       end_blk_reg;
    assign pf_blk_next  = (host_owns && (cmd_release || cmd_flush)) ? 1'b0 :
                          (!host_owns && blk_full && !cmd_flush)     ? 1'b1 :
                                                                       pf_blk_reg;

    assign pf_irq_next = blk_full && !cmd_flush && !dma_reg;
    assign me_irq_next = blk_end && !cmd_flush;

    assign dma_next = mode_wr ? reg_wdata[BCRX_BIT_DMA] : dma_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Host read side.

    // A read past the stored bytes returns zero and leaves the pointer alone, so
    // a host that reads too far never runs into bytes the receiver still owns.
    // one byte per read
    wire logic rd_more = host_owns && (rd_cnt_reg < wr_cnt_reg);
    wire logic rd_step = win_rd && rd_more;

    assign rd_idx_next = (state_next == BCRX_ST_FILL) ? BCRX_IDX_ZERO :
                         rd_step                      ? rd_idx_reg + BCRX_IDX_ONE :
                                                        rd_idx_reg;
    assign rd_cnt_next = (state_next == BCRX_ST_FILL) ? BCRX_CNT_ZERO :
                         rd_step                      ? rd_cnt_reg + BCRX_CNT_ONE :
                                                        rd_cnt_reg;

    wire logic rd_event  = reg_rd && reg_hit(reg_addr, BCRX_ADDR_EVENT);
    wire logic rd_status = reg_rd && reg_hit(reg_addr, BCRX_ADDR_STCMD);
    wire logic rd_cntlo  = reg_rd && reg_hit(reg_addr, BCRX_ADDR_CNTLO);
    wire logic rd_cnthi  = reg_rd && reg_hit(reg_addr, BCRX_ADDR_CNTHI);

    // The views are assembled from the field positions, so a field that moves
    // only touches the package.
    logic [BCRX_DATA_W-1:0]  event_view;
    logic [BCRX_DATA_W-1:0]  status_view;
    logic [BCRX_DATA_W-1:0]  cnthi_view;

    always_comb begin
        event_view                             = BCRX_BYTE_ZERO;
        event_view[BCRX_BIT_EVT_END]           = end_blk_reg;
        event_view[BCRX_BIT_EVT_FULL]          = pf_blk_reg;
        status_view                            = BCRX_BYTE_ZERO;
        status_view[BCRX_BIT_READABLE]         = host_owns;
        cnthi_view                             = BCRX_BYTE_ZERO;
        cnthi_view[BCRX_BIT_DMA]               = dma_reg;
        cnthi_view[BCRX_BIT_OV]                = ov_reg;
        cnthi_view[BCRX_FRM_W-BCRX_DATA_W-1:0] = frm_cnt_reg[BCRX_FRM_W-1:BCRX_DATA_W];
    end

    always_comb begin
        rdata_next = BCRX_BYTE_ZERO;
        if (win_rd) begin
            rdata_next = rd_more ? store_q : BCRX_BYTE_ZERO;
        end else if (rd_event) begin
            rdata_next = event_view;
        end else if (rd_status) begin
            rdata_next = status_view;
        end else if (rd_cntlo) begin
            rdata_next = frm_cnt_reg[BCRX_DATA_W-1:0];
        end else if (rd_cnthi) begin
            rdata_next = cnthi_view;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State registers.

    // Every group resets on rst_b and holds while clk_en is low.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            state_reg <= BCRX_ST_FILL;
            ready_reg <= 1'b1;
        end else if (clk_en) begin
            state_reg <= state_next;
            ready_reg <= ready_next;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            wr_cnt_reg <= BCRX_CNT_ZERO;
            rd_idx_reg <= BCRX_IDX_ZERO;
            rd_cnt_reg <= BCRX_CNT_ZERO;
        end else if (clk_en) begin
            wr_cnt_reg <= wr_cnt_next;
            rd_idx_reg <= rd_idx_next;
            rd_cnt_reg <= rd_cnt_next;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            frm_cnt_reg <= BCRX_FRM_ZERO;
            ov_reg      <= 1'b0;
            dma_reg     <= BCRX_DMA_RST;
        end else if (clk_en) begin
            frm_cnt_reg <= frm_cnt_next;
            ov_reg      <= ov_next;
            dma_reg     <= dma_next;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            end_blk_reg <= 1'b0;
            pf_blk_reg  <= 1'b0;
            pf_irq_reg  <= 1'b0;
            me_irq_reg  <= 1'b0;
        end else if (clk_en) begin
            end_blk_reg <= end_blk_next;
            pf_blk_reg  <= pf_blk_next;
            pf_irq_reg  <= pf_irq_next;
            me_irq_reg  <= me_irq_next;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            rdata_reg <= BCRX_BYTE_ZERO;
        end else if (clk_en) begin
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata              = rdata_reg;
    assign rx_byte_ready          = ready_reg;
    assign rx_pool_full_irq       = pf_irq_reg;
    assign rx_message_end_irq     = me_irq_reg;
    assign rx_queue_readable_flag = host_owns;
    assign rx_dma_mode            = dma_reg;

endmodule

`default_nettype wire

// ===== src/bcrx_pkg.sv
// Purpose : Shared constants for the B-channel receive queue host read path.
// Assumes : 8-bit register port, one clock domain.
// Notes   : The register window repeats at a second range offset by 0x40.
package bcrx_pkg;

    localparam int BCRX_DATA_W = 8;
    localparam int BCRX_ADDR_W = 8;
    localparam int BCRX_IDX_W  = 6;
    localparam int BCRX_CNT_W  = 7;
    localparam int BCRX_FRM_W  = 12;
    localparam int BCRX_DEPTH  = 64;

    // Address bit 6 selects the mirrored range and is ignored by decode.
    localparam logic [7:0] BCRX_MIRROR_MASK = 8'hBF;
    localparam logic [7:0] BCRX_QUEUE_LAST  = 8'h1F;
    localparam logic [7:0] BCRX_ADDR_EVENT  = 8'h20;
    localparam logic [7:0] BCRX_ADDR_STCMD  = 8'h21;
    localparam logic [7:0] BCRX_ADDR_CNTLO  = 8'h25;
    localparam logic [7:0] BCRX_ADDR_CNTHI  = 8'h2D;

    // Field positions.
    localparam int BCRX_BIT_EVT_END  = 7;
    localparam int BCRX_BIT_EVT_FULL = 6;
    localparam int BCRX_BIT_READABLE = 4;
    localparam int BCRX_BIT_RELEASE  = 7;
    localparam int BCRX_BIT_FLUSH    = 6;
    localparam int BCRX_BIT_DMA = 7;
    localparam int BCRX_BIT_OV  = 4;

    // Counts and reset values.
    localparam logic [6:0]  BCRX_CNT_ZERO   = 7'h00;
    localparam logic [6:0]  BCRX_CNT_ONE    = 7'h01;
    localparam logic [6:0]  BCRX_BLOCK_LAST = 7'h3F;
    localparam logic [5:0]  BCRX_IDX_ZERO   = 6'h00;
    localparam logic [5:0]  BCRX_IDX_ONE    = 6'h01;
    localparam logic [11:0] BCRX_FRM_ZERO   = 12'h000;
    localparam logic [11:0] BCRX_FRM_ONE    = 12'h001;
    localparam logic [11:0] BCRX_FRM_MAX    = 12'hFFF;
    localparam logic [7:0]  BCRX_BYTE_ZERO  = 8'h00;
    localparam logic        BCRX_DMA_RST    = 1'b0;

    typedef enum logic [1:0] {
        BCRX_ST_FILL = 2'b00,
        BCRX_ST_HOST = 2'b01
    } bcrx_state_t;

endpackage

// ===== src/bcrx_store.sv
// Purpose : 64-byte storage array of the receive queue.
// Assumes : One write port from the receiver, one combinational read port.
// Notes   : No reset on the array; contents are only read inside a block the host owns.
`timescale 1ns/100ps
`default_nettype none

module bcrx_store (
    input  wire logic                               sys_clk,
    input  wire logic                               clk_en,
    input  wire logic                               wr_en,
    input  wire logic [bcrx_pkg::BCRX_IDX_W-1:0]    wr_idx,
    input  wire logic [bcrx_pkg::BCRX_DATA_W-1:0]   wr_data,
    input  wire logic [bcrx_pkg::BCRX_IDX_W-1:0]    rd_idx,
    output logic      [bcrx_pkg::BCRX_DATA_W-1:0]   rd_data
);
    import bcrx_pkg::*;

    logic [BCRX_DATA_W-1:0] mem [0:BCRX_DEPTH-1];

    always_ff @(posedge sys_clk) begin
        if (clk_en && wr_en) begin
            mem[wr_idx] <= wr_data;
        end
    end

    assign rd_data = mem[rd_idx];

endmodule

`default_nettype wire
